// File: hdl/drive_status_pkg.sv
// ----------------------------------------------------------------
// shared constants and types of the drive status word bank
// ----------------------------------------------------------------
package drive_status_pkg;

  // ----------------------------------------------------------------
  // parameter addresses, as seen on the parameter interface
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W               = 16;
  localparam int unsigned WORD_W               = 16;
  localparam logic [15:0] ACTION_WORD_ADDR     = 16'h1c08;
  localparam logic [15:0] LAST_STOP_ERROR_ADDR = 16'h1c0a;
  localparam logic [15:0] SAVED_WARNING_ADDR   = 16'h1c18;

  // ----------------------------------------------------------------
  // saved / active warning word bit positions
  // ----------------------------------------------------------------
  localparam int unsigned WARN_GENERAL       = 0;
  localparam int unsigned WARN_STAGE_TEMP    = 1;
  localparam int unsigned WARN_MOTOR_TEMP    = 2;
  localparam int unsigned WARN_STAGE_I2T     = 4;
  localparam int unsigned WARN_MOTOR_I2T     = 5;
  localparam int unsigned WARN_BRAKE_I2T     = 6;
  localparam int unsigned WARN_CAN           = 7;
  localparam int unsigned WARN_ENCODER       = 8;
  localparam int unsigned WARN_SERIAL        = 9;
  localparam int unsigned WARN_SAFE_OFF      = 10;
  localparam int unsigned WARN_UNDERVOLT     = 11;
  localparam int unsigned WARN_FIELDBUS2     = 12;
  localparam int unsigned WARN_POS_INVALID   = 13;
  localparam int unsigned WARN_ETHERNET      = 14;

  // bits 3 and 15 are reserved and always zero
  localparam logic [15:0] WARN_USED_MASK     = 16'h7ff7;
  // bits 10, 11, 13 follow their cause instead of latching
  localparam logic [15:0] WARN_AUTO_MASK     = 16'h2c00;

  // ----------------------------------------------------------------
  // action word bit positions
  // ----------------------------------------------------------------
  localparam int unsigned ACT_WARNING        = 0;
  localparam int unsigned ACT_CLASS_LO       = 1;
  localparam int unsigned ACT_CLASS_HI       = 4;
  localparam int unsigned ACT_STANDSTILL     = 6;
  localparam int unsigned ACT_CLOCKWISE      = 7;
  localparam int unsigned ACT_COUNTER_CW     = 8;
  localparam int unsigned ACT_PG_IDLE        = 11;
  localparam int unsigned ACT_PG_DECEL       = 12;
  localparam int unsigned ACT_PG_ACCEL       = 13;
  localparam int unsigned ACT_PG_CONSTANT    = 14;

  // ----------------------------------------------------------------
  // motion figures
  // ----------------------------------------------------------------
  localparam int unsigned SPEED_W            = 16;
  localparam int unsigned STANDSTILL_RPM     = 9;
  localparam logic [15:0] RESET_WORD         = 16'h0000;

  // profile generator phase reported by the motion logic
  typedef enum logic [1:0] {
    PG_IDLE,
    PG_DECEL,
    PG_ACCEL,
    PG_CONSTANT
  } pg_phase_t;

  // parameter read/write request
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] addr;
  } param_req_t;

  // parameter answer
  typedef struct packed {
    logic              valid;
    logic              error;
    logic [WORD_W-1:0] data;
  } param_rsp_t;

endpackage : drive_status_pkg

// File: hdl/sync_two_flop.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// two-flop synchroniser for asynchronous pin levels
// ----------------------------------------------------------------
module sync_two_flop
  import drive_status_pkg::*;
#(
  parameter int unsigned WIDTH = 2
)(
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] pinLevel,
  output logic      [WIDTH-1:0] syncLevel
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] first;   // metastable stage, read only by second
    logic [WIDTH-1:0] second;  // safe to use
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // shift the pin through both stages
  always_comb
  begin
    next_state.first  = pinLevel;
    next_state.second = state.first;
  end

  // registers, cleared to inactive
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign syncLevel = state.second;

endmodule : sync_two_flop

// File: hdl/drive_status_words.sv
`timescale 1ns/1ns
module drive_status_words
  import drive_status_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst_b,
  // warning causes from internal monitors (same clock)
  input  wire logic               generalWarning,
  input  wire logic               stageTempHigh,
  input  wire logic               motorTempHigh,
  input  wire logic               stageOverload,
  input  wire logic               motorOverload,
  input  wire logic               brakeOverload,
  input  wire logic               canWarning,
  input  wire logic               encoderWarning,
  input  wire logic               serialWarning,
  input  wire logic               undervoltage,
  input  wire logic               fieldbus2Warning,
  input  wire logic               positionInvalid,
  input  wire logic               ethernetWarning,
  // safe-off pins, asynchronous, high while active
  input  wire logic               safe_off_input_a,
  input  wire logic               safe_off_input_b,
  // fault clear and error state
  input  wire logic               fault_clear_command,
  input  wire logic [3:0]         errorClassActive,
  input  wire logic               stopFaultEvent,
  input  wire logic [WORD_W-1:0]  stopFaultNumber,
  // motion state
  input  wire logic [SPEED_W-1:0] actualSpeedRpm,
  input  wire pg_phase_t          profilePhase,
  // parameter interface
  input  wire param_req_t         paramReq,
  output param_rsp_t              paramRsp,
  // live words for the rest of the drive
  output logic      [WORD_W-1:0]  active_warning_word,
  output logic      [WORD_W-1:0]  saved_warning_word,
  output logic      [WORD_W-1:0]  action_word,
  output logic      [WORD_W-1:0]  last_stop_error
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // every register of the bank except the synchroniser flops lives in this one struct, so the
  // reset branch and the clocked process stay a single line each
  typedef struct packed {
    logic [WORD_W-1:0] activeWarn;  // current warning causes
    logic [WORD_W-1:0] savedWarn;   // latched warnings
    logic [WORD_W-1:0] action;      // action word
    logic [WORD_W-1:0] stopError;   // last stop fault number
    param_rsp_t        rsp;         // parameter answer
  } bank_state_t;

  bank_state_t state;
  bank_state_t next_state;

  logic [1:0]        safeOffSync;   // synchronised safe-off pins
  logic [WORD_W-1:0] causeWord;     // assembled active word
  logic [SPEED_W-1:0] speedMag;     // speed magnitude
  logic              speedNeg;      // negative speed sign
  logic [WORD_W-1:0] motionBits;    // standstill and direction flags
  param_rsp_t        answerNext;    // parameter answer before its register

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  // safe-off pins come from outside the clock domain; two flops
  // cost two cycles on bit 10 but keep metastability out
  sync_two_flop #(
    .WIDTH     (2)
  ) safeOffSyncer (
    .clock     (clock),
    .rst_b     (rst_b),
    .pinLevel  ({safe_off_input_b, safe_off_input_a}),
    .syncLevel (safeOffSync)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // true when the address names one of the three words
  // anything else in the parameter space answers with an error
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == ACTION_WORD_ADDR) || (a == LAST_STOP_ERROR_ADDR)
               || (a == SAVED_WARNING_ADDR);
  endfunction : isMapped

  // read value of a mapped word, zero elsewhere
  function automatic logic [WORD_W-1:0] readWord(input logic [ADDR_W-1:0] a,
                                                 input bank_state_t s);
    readWord = RESET_WORD;
    if (a == ACTION_WORD_ADDR)
    begin
      // motion and error flags
      readWord = s.action;
    end
    else if (a == LAST_STOP_ERROR_ADDR)
    begin
      // number of the last stop fault
      readWord = s.stopError;
    end
    else if (a == SAVED_WARNING_ADDR)
    begin
      // latched warnings
      readWord = s.savedWarn;
    end
  endfunction : readWord

  // ----------------------------------------------------------------
  // active warning word assembly
  // ----------------------------------------------------------------
  // each cause lands on its own bit, one meaning active
  // reserved bits never see a cause, the mask below is a second guard
  always_comb
  begin
    causeWord                   = RESET_WORD;
    causeWord[WARN_GENERAL]     = generalWarning;
    causeWord[WARN_STAGE_TEMP]  = stageTempHigh;
    causeWord[WARN_MOTOR_TEMP]  = motorTempHigh;
    causeWord[WARN_STAGE_I2T]   = stageOverload;
    causeWord[WARN_MOTOR_I2T]   = motorOverload;
    causeWord[WARN_BRAKE_I2T]   = brakeOverload;
    causeWord[WARN_CAN]         = canWarning;
    causeWord[WARN_SERIAL]      = serialWarning;
    causeWord[WARN_FIELDBUS2]   = fieldbus2Warning;
    causeWord[WARN_ETHERNET]    = ethernetWarning;
    causeWord[WARN_ENCODER]     = encoderWarning;
    // either channel is enough to flag safe-off
    causeWord[WARN_SAFE_OFF]    = safeOffSync[0] | safeOffSync[1];
    causeWord[WARN_UNDERVOLT]   = undervoltage;
    causeWord[WARN_POS_INVALID] = positionInvalid;
    // reserved positions forced low whatever happens above
    causeWord                   = causeWord & WARN_USED_MASK;
  end

  // ----------------------------------------------------------------
  // speed magnitude for standstill and direction
  // ----------------------------------------------------------------
  // two's complement speed, positive is clockwise
  always_comb
  begin
    speedNeg = actualSpeedRpm[SPEED_W-1];
    if (speedNeg)
    begin
      // negate; full-scale negative stays large, so it still moves
      speedMag = SPEED_W'(~actualSpeedRpm + 1'b1);
    end
    else
    begin
      // positive or zero passes unchanged
      speedMag = actualSpeedRpm;
    end
  end

  // ----------------------------------------------------------------
  // motion flags
  // ----------------------------------------------------------------
  // standstill hides the direction: a drive creeping below the
  // threshold reports neither clockwise nor counter-clockwise,
  // so exactly one of the three flags is set in every cycle
  always_comb
  begin
    motionBits = RESET_WORD;
    if (speedMag < SPEED_W'(STANDSTILL_RPM))
    begin
      // slower than the threshold in either direction
      motionBits[ACT_STANDSTILL] = 1'b1;
    end
    else if (speedNeg)
    begin
      // negative speed turns counter-clockwise
      motionBits[ACT_COUNTER_CW] = 1'b1;
    end
    else
    begin
      // positive speed turns clockwise
      motionBits[ACT_CLOCKWISE]  = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // parameter answer
  // ----------------------------------------------------------------
  // every request gets exactly one answer one cycle later, so a
  // master never needs a timeout; the cost is that a refused
  // write still takes the answer slot like a good read
  always_comb
  begin
    answerNext       = '0;
    answerNext.valid = paramReq.read | paramReq.write;
    // a write or an unmapped read is refused, nothing stored
    answerNext.error = paramReq.write
                       | (paramReq.read & ~isMapped(paramReq.addr));
    if (paramReq.read & ~paramReq.write)
    begin
      // plain read: the word as registered in this cycle
      answerNext.data = readWord(paramReq.addr, state);
    end
    else
    begin
      // idle, write or clash: data held at zero
      answerNext.data = RESET_WORD;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // one process builds the whole next state, so nothing can be
  // left without a value on some path
  always_comb
  begin
    next_state = state;

    // active word registered; the saved word trails it by one cycle
    next_state.activeWarn = causeWord;

    // latching: a clear drops old bits but a cause present in the
    // same cycle still sets, so no event is lost on the clear edge
    if (fault_clear_command)
    begin
      // only what is active right now survives the clear
      next_state.savedWarn = state.activeWarn;
    end
    else
    begin
      // self-clearing bits just track their cause
      next_state.savedWarn = (state.savedWarn & ~WARN_AUTO_MASK)
                             | state.activeWarn;
    end
    next_state.savedWarn = next_state.savedWarn & WARN_USED_MASK;

    // action word rebuilt every cycle, reserved bits zero
    next_state.action                       = RESET_WORD;
    next_state.action[ACT_WARNING]          = |state.activeWarn;
    next_state.action[ACT_CLASS_HI:ACT_CLASS_LO] = errorClassActive;
    // standstill and direction flags come ready-made
    next_state.action = next_state.action | motionBits;
    // exactly one phase bit is set at a time
    unique case (profilePhase)
      PG_IDLE:     next_state.action[ACT_PG_IDLE]     = 1'b1;
      PG_DECEL:    next_state.action[ACT_PG_DECEL]    = 1'b1;
      PG_ACCEL:    next_state.action[ACT_PG_ACCEL]    = 1'b1;
      PG_CONSTANT: next_state.action[ACT_PG_CONSTANT] = 1'b1;
    endcase

    // stop fault number kept until the next stop fault
    if (stopFaultEvent)
    begin
      next_state.stopError = stopFaultNumber;
    end

    // parameter answer: one-cycle pulse after each request
    next_state.rsp = answerNext;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // all words start from zero; the warning and action words fill
  // in one and two cycles after release
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a flip-flop, so no read sees a glitch
  assign paramRsp            = state.rsp;
  assign active_warning_word = state.activeWarn;
  assign saved_warning_word  = state.savedWarn;
  assign action_word         = state.action;
  assign last_stop_error     = state.stopError;

endmodule : drive_status_words

// File: verif/drive_status_words_assertions.sv
`timescale 1ns/1ns
// ------
// port checks of the status word bank
// ------
module drive_status_words_assertions
  import drive_status_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst_b,
  input  wire logic               fault_clear_command,
  input  wire logic [3:0]         errorClassActive,
  input  wire logic               stopFaultEvent,
  input  wire logic [WORD_W-1:0]  stopFaultNumber,
  input  wire logic [SPEED_W-1:0] actualSpeedRpm,
  input  wire pg_phase_t          profilePhase,
  input  wire param_req_t         paramReq,
  input  wire param_rsp_t         paramRsp,
  input  wire logic [WORD_W-1:0]  active_warning_word,
  input  wire logic [WORD_W-1:0]  saved_warning_word,
  input  wire logic [WORD_W-1:0]  action_word,
  input  wire logic [WORD_W-1:0]  last_stop_error
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [WORD_W-1:0] pick;      // word the address selects
  logic              hit;       // address is mapped
  logic [2:0]        motion;    // expected ccw, cw, standstill
  logic              anyActive; // some warning active
  // reference decode, kept apart from the design's own
  always_comb
  begin
    pick = '0;
    hit = 1'b1;
    case (paramReq.addr)
      ACTION_WORD_ADDR:     pick = action_word;
      LAST_STOP_ERROR_ADDR: pick = last_stop_error;
      SAVED_WARNING_ADDR:   pick = saved_warning_word;
      default:              hit = 1'b0;
    endcase
    motion = 3'h1;
    if ($signed(actualSpeedRpm) >= 16'sd9) motion = 3'h2;
    if ($signed(actualSpeedRpm) <= -16'sd9) motion = 3'h4;
    anyActive = |active_warning_word;
  end
  a_clear_wipes: assert property (fault_clear_command && active_warning_word == '0
    |=> saved_warning_word == '0) else $error("clear left saved bits");
  a_saved_latch: assert property (!fault_clear_command |=>
    ($past(saved_warning_word) & ~WARN_AUTO_MASK & ~saved_warning_word) == '0)
    else $error("latched bit dropped");
  a_set_wins: assert property (1'b1 |=>
    ($past(active_warning_word) & ~saved_warning_word) == '0) else $error("warning not saved");
  a_auto_follow: assert property (1'b1 |=>
    ((saved_warning_word ^ $past(active_warning_word)) & WARN_AUTO_MASK) == '0)
    else $error("self-clearing bit wrong");
  a_reserved_zero: assert property (
    ((saved_warning_word | active_warning_word) & ~WARN_USED_MASK) == '0
    && (action_word & 16'h8620) == '0) else $error("reserved bit set");
  a_bus_answer: assert property (paramReq.read || paramReq.write |=> paramRsp.valid)
    else $error("no answer");
  a_write_refused: assert property (paramReq.write |=> paramRsp.error
    && paramRsp.data == '0) else $error("write not refused");
  a_read_data: assert property (paramReq.read && !paramReq.write |=>
    paramRsp.data == $past(pick) && paramRsp.error == !$past(hit)) else $error("bad read");
  a_class_bits: assert property (1'b1 |=> action_word[4:0] ==
    {$past(errorClassActive), $past(anyActive)}) else $error("class bits wrong");
  a_motion_bits: assert property (1'b1 |=> action_word[8:6] == $past(motion))
    else $error("motion bits wrong");
  a_phase_bits: assert property (1'b1 |=>
    action_word[14:11] == 4'h1 << $past(profilePhase)) else $error("phase bits wrong");
  a_stop_capture: assert property (stopFaultEvent |=>
    last_stop_error == $past(stopFaultNumber)) else $error("stop fault not captured");
  a_stop_hold: assert property (!stopFaultEvent |=> $stable(last_stop_error))
    else $error("stop fault moved");
  c_clear: cover property (fault_clear_command && saved_warning_word != '0);
  c_refused: cover property (paramRsp.valid && paramRsp.error);
  c_stop: cover property (stopFaultEvent);
endmodule : drive_status_words_assertions

bind drive_status_words drive_status_words_assertions i_drive_status_words_assertions (
  .clock(clock), .rst_b(rst_b), .fault_clear_command(fault_clear_command),
  .errorClassActive(errorClassActive), .stopFaultEvent(stopFaultEvent),
  .stopFaultNumber(stopFaultNumber), .actualSpeedRpm(actualSpeedRpm),
  .profilePhase(profilePhase), .paramReq(paramReq), .paramRsp(paramRsp),
  .active_warning_word(active_warning_word), .saved_warning_word(saved_warning_word),
  .action_word(action_word), .last_stop_error(last_stop_error));

// File: verif/param_master.sv
`timescale 1ns/1ns
// ------
// fieldbus master model on the parameter port
// ------
module param_master
  import drive_status_pkg::*;
(
  input  wire logic       clock,
  output param_req_t      paramReq,
  input  wire param_rsp_t paramRsp
);
  initial paramReq = '0;
  // one strobe held over its edge; released address shows its inverse
  task automatic access(input logic wr, input logic [ADDR_W-1:0] addr,
                        output logic [WORD_W-1:0] data, output logic err);
    int n;
    @(posedge clock);
    #1;
    paramReq = '{read: !wr, write: wr, addr: addr};
    @(posedge clock);
    #1;
    paramReq = '{read: 1'b0, write: 1'b0, addr: ~addr};
    data = 'x;
    err = 1'bx;
    n = 0;
    // bounded wait, a lost answer shows as unknown data
    while (paramRsp.valid !== 1'b1 && n < 4)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (paramRsp.valid === 1'b1)
    begin
      data = paramRsp.data;
      err = paramRsp.error;
    end
  endtask : access
endmodule : param_master

// File: verif/drive_status_words_tb.sv
`timescale 1ns/1ns
module drive_status_words_tb
  import drive_status_pkg::*;
();
  logic               clock = 1'b0;      // 250 MHz
  logic               rst_b = 1'b0;      // low at start
  logic [15:0]        causes = '0;       // causes by saved bit
  logic               offB = 1'b0;       // second safe-off pin
  logic               faultClear = 1'b0;
  logic [3:0]         errClass = '0;
  logic               stopEvent = 1'b0;
  logic [WORD_W-1:0]  stopNum = '0;
  logic [SPEED_W-1:0] speed = '0;
  pg_phase_t          phase = PG_IDLE;
  param_req_t         paramReq;
  param_rsp_t         paramRsp;
  logic [WORD_W-1:0]  rdData;
  logic               rdErr;
  logic [WORD_W-1:0]  activeWord;        // live active word
  logic [WORD_W-1:0]  savedWord;         // live saved word
  logic [WORD_W-1:0]  actionWord;        // live action word
  logic [WORD_W-1:0]  lastStop;          // live stop fault number
  int                 numErrors = 0;
  int                 totalChecks = 0;
  always #2 clock = ~clock;
  drive_status_words i_drive_status_words (
    .clock(clock), .rst_b(rst_b), .generalWarning(causes[0]), .stageTempHigh(causes[1]),
    .motorTempHigh(causes[2]), .stageOverload(causes[4]), .motorOverload(causes[5]),
    .brakeOverload(causes[6]), .canWarning(causes[7]), .encoderWarning(causes[8]),
    .serialWarning(causes[9]), .undervoltage(causes[11]), .fieldbus2Warning(causes[12]),
    .positionInvalid(causes[13]), .ethernetWarning(causes[14]),
    .safe_off_input_a(causes[10]), .safe_off_input_b(offB),
    .fault_clear_command(faultClear), .errorClassActive(errClass),
    .stopFaultEvent(stopEvent), .stopFaultNumber(stopNum), .actualSpeedRpm(speed),
    .profilePhase(phase), .paramReq(paramReq), .paramRsp(paramRsp),
    .active_warning_word(activeWord), .saved_warning_word(savedWord),
    .action_word(actionWord), .last_stop_error(lastStop));
  param_master i_param_master (.clock(clock), .paramReq(paramReq), .paramRsp(paramRsp));
  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    totalChecks++;
    if (seen !== expd)
    begin
      numErrors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask : check
  // inputs move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic rd(input logic [15:0] a, input logic [15:0] expd, input logic expErr);
    i_param_master.access(1'b0, a, rdData, rdErr);
    check(rdData, expd);
    check({15'h0, rdErr}, {15'h0, expErr});
  endtask : rd
  task automatic pulse_clear();
    faultClear = 1'b1;
    step(1);
    faultClear = 1'b0;
    step(2);
  endtask : pulse_clear
  // writes and a hole in the map are answered with an error
  task automatic t_refusals();
    logic [15:0] adr [3] = '{ACTION_WORD_ADDR, LAST_STOP_ERROR_ADDR, SAVED_WARNING_ADDR};
    // idle drive at rest: standstill and idle phase are set
    logic [15:0] idle [3] = '{16'h0840, 16'h0000, 16'h0000};
    for (int i = 0; i < 3; i++)
    begin
      i_param_master.access(1'b1, adr[i], rdData, rdErr);
      check({15'h0, rdErr}, 16'h0001);
      check(rdData, 16'h0000);
      rd(adr[i], idle[i], 1'b0);
    end
    rd(16'h1c0c, 16'h0000, 1'b1);
  endtask : t_refusals
  // each bit alone: set, cause gone, then clear
  task automatic t_warn_bits();
    logic [15:0] bitv;
    for (int i = 0; i < 16; i++)
    begin
      bitv = (16'h0001 << i) & WARN_USED_MASK;
      causes = bitv;
      step(6);
      check(activeWord, bitv);
      rd(SAVED_WARNING_ADDR, bitv, 1'b0);
      causes = '0;
      step(6);
      rd(SAVED_WARNING_ADDR, bitv & ~WARN_AUTO_MASK, 1'b0);
      check(savedWord, bitv & ~WARN_AUTO_MASK);
      pulse_clear();
      rd(SAVED_WARNING_ADDR, 16'h0000, 1'b0);
    end
  endtask : t_warn_bits
  // clear while a cause stays; second safe-off pin
  task automatic t_clear_held();
    causes[7] = 1'b1;
    step(4);
    pulse_clear();
    rd(SAVED_WARNING_ADDR, 16'h0080, 1'b0);
    causes[7] = 1'b0;
    offB = 1'b1;
    step(6);
    rd(SAVED_WARNING_ADDR, 16'h0480, 1'b0);
    offB = 1'b0;
    step(6);
    pulse_clear();
    rd(SAVED_WARNING_ADDR, 16'h0000, 1'b0);
  endtask : t_clear_held
  // speeds around the 9 rpm edge, every class and phase
  task automatic t_action();
    logic [15:0] spd [6] = '{16'h0000, 16'h0008, 16'hfff8, 16'h0009, 16'hfff7, 16'h00c8};
    logic [2:0]  mot [6] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h4, 3'h2};
    logic [15:0] expd;
    for (int k = 0; k < 6; k++)
    begin
      speed = spd[k];
      errClass = 4'h1 << (k % 4);
      phase = pg_phase_t'(k % 4);
      causes[0] = k[0];
      step(4);
      expd = '0;
      expd[14:11] = 4'h1 << (k % 4);
      expd[8:6] = mot[k];
      expd[4:1] = 4'h1 << (k % 4);
      expd[0] = k[0];
      rd(ACTION_WORD_ADDR, expd, 1'b0);
      check(actionWord, expd);
    end
    causes = '0;
    pulse_clear();
  endtask : t_action
  // capture on the strobe only, back to back strobes keep the last
  task automatic t_stop_fault();
    stopNum = 16'h00a5;
    stopEvent = 1'b1;
    step(1);
    stopEvent = 1'b0;
    stopNum = 16'h5a3c;
    step(2);
    rd(LAST_STOP_ERROR_ADDR, 16'h00a5, 1'b0);
    stopEvent = 1'b1;
    step(1);
    stopNum = 16'hffff;
    step(1);
    stopEvent = 1'b0;
    rd(LAST_STOP_ERROR_ADDR, 16'hffff, 1'b0);
    check(lastStop, 16'hffff);
  endtask : t_stop_fault
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    step(2);
    rst_b = 1'b1;
    step(1);
    t_refusals();
    t_warn_bits();
    t_clear_held();
    t_action();
    t_stop_fault();
    tally_and_finish();
  end
  // run needs about 430 cycles
  initial
  begin
    #40000;
    numErrors++;
    tally_and_finish();
  end
endmodule : drive_status_words_tb
